// File: src/lmcr_pkg.sv
// Package for the logic-module control register bank: offsets, fields, reset values
package lmcr_pkg;
  // Register byte offsets within the module region
  localparam logic [27:0] OFS_OSC1     = 28'h000_0000;
  localparam logic [27:0] OFS_OSC2     = 28'h000_0004;
  localparam logic [27:0] OFS_LOCK     = 28'h000_0008;
  localparam logic [27:0] OFS_LEDS     = 28'h000_000C;
  localparam logic [27:0] OFS_IRQ      = 28'h000_0010;
  localparam logic [27:0] OFS_SWITCH   = 28'h000_0014;
  localparam logic [27:0] OFS_CTRL     = 28'h000_0018;
  // Information ROM window at the top of the region
  localparam logic [27:0] OFS_ROM_BASE = 28'hFFF_FF00;
  localparam logic [27:0] ROM_MASK     = 28'hFFF_FF80;
  localparam int          ROM_WORDS    = 32;
  localparam int          ROM_IDX_LSB  = 2;
  localparam int          ROM_IDX_W    = 5;
  // Lock register fields
  localparam logic [15:0] UNLOCK_KEY   = 16'hA05F;
  localparam int          LOCKED_BIT   = 16;
  localparam int          KEY_MSB      = 15;
  // Control register fields and reset values
  localparam int          DISP_EN_BIT  = 2;
  localparam int          DISP_SEL_MSB = 1;
  localparam logic        DISP_EN_RST  = 1'b1;
  localparam logic [1:0]  DISP_SEL_RST = 2'h0;
  // Display routing choices
  typedef enum logic [1:0] {
    LMCR_DISP_PANEL,
    LMCR_DISP_VGA16,
    LMCR_DISP_AUX_LCD,
    LMCR_DISP_VGA24
  } lmcr_disp_e;
  // ROM entry layout
  localparam logic [23:0] BUILD_TAG    = 24'hFF_FFFF;
  localparam logic [31:0] ROM_EMPTY    = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
endpackage

// File: src/lmcr_regs.sv
// Logic-module control registers: oscillator lock, LEDs, button latch, switches, display, info ROM
//
// Behaviour
// - Writing key A05F to lock field with bits 31:16 zero unlocks oscillator divisor writes.
// - Writing any other value locks; divisor writes are then ignored.
// - Lock register bit 16 reads 1 when locked, 0 when unlocked.
// - LED bits drive LEDs active low; stored 0 lights LED.
// - Button latch sets on a press and holds until software clears.
// - Button latch drives the interrupt request output.
// - Writing 0 to button latch clears it, acknowledging the interrupt.
// - Writing 1 to button latch sets it like a press.
// - Switch register returns eight DIP elements, 0 meaning closed.
// - Control bit 2 enables the display; resets to 1.
// - Control bits 1:0 select display route; resets to 00.
// - Control bits 7:3 reserved, no function, read zero.
// - Read-only 32-word information ROM at top of region.
// - ROM word of zero marks an empty slot to skip.
// - Entry bits 31:28 stack position, 27:24 base address bits.
// - Entry middle 16 bits peripheral type; FFFF marks build entry.
// - Entry low byte is revision, major and minor nibbles.
// - Last ROM word holds build number, upper bits all ones.
module lmcr_regs
  import lmcr_pkg::*;
#(
  parameter int           LED_W      = 8,
  parameter int           SW_W       = 8,
  parameter logic [31:0]  OSC1_RST   = 32'h0000_0000,
  parameter logic [31:0]  OSC2_RST   = 32'h0000_0000,
  parameter logic [3:0]   BUILD_MAJ  = 4'h1,
  parameter logic [3:0]   BUILD_MIN  = 4'h0,
  // Peripheral entries; value arbitrary, all slots empty by default
  parameter logic [31:0]  ROM_INIT [0:30] = '{default: 32'h0000_0000}
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [27:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              button_press,
  input  wire logic [SW_W-1:0]   dip_switch_in,
  output logic [LED_W-1:0]       user_led_outputs_n,
  output logic                   button_irq,
  output logic                   display_enable,
  output logic [1:0]             display_select,
  output logic [31:0]            osc1_div,
  output logic [31:0]            osc2_div
);

  // Information ROM contents, last word is the build number
  logic [31:0] rom [0:ROM_WORDS-1];
  always_comb begin
    for (int i = 0; i < ROM_WORDS - 1; i++) begin
      rom[i] = ROM_INIT[i];
    end
    rom[ROM_WORDS-1] = {BUILD_TAG, BUILD_MAJ, BUILD_MIN};
  end

  // Address decode helper
  // Word offsets only; the two byte-lane bits are ignored
  function automatic logic hit(input logic [27:0] a, input logic [27:0] ofs);
    hit = (a[27:ROM_IDX_LSB] == ofs[27:ROM_IDX_LSB]);
  endfunction

  logic        wr_acc;
  logic        rd_setup;
  logic        in_rom;
  logic        mapped;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign in_rom   = (paddr & ROM_MASK) == OFS_ROM_BASE;
  assign mapped   = in_rom || hit(paddr, OFS_OSC1) || hit(paddr, OFS_OSC2) || hit(paddr, OFS_LOCK)
                    || hit(paddr, OFS_LEDS) || hit(paddr, OFS_IRQ) || hit(paddr, OFS_SWITCH)
                    || hit(paddr, OFS_CTRL);

  // Zero-wait slave; unmapped access answers with an error
  // Writes to read-only words are taken without an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Pin synchronisers: three stages, level taken when stages two and three agree
  logic              btn_s1_ff, btn_s2_ff, btn_s3_ff, btn_lvl_ff;
  logic [SW_W-1:0]   sw_s1_ff, sw_s2_ff, sw_s3_ff, sw_lvl_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_s1_ff  <= 1'b0;
      btn_s2_ff  <= 1'b0;
      btn_s3_ff  <= 1'b0;
      btn_lvl_ff <= 1'b0;
      sw_s1_ff   <= '0;
      sw_s2_ff   <= '0;
      sw_s3_ff   <= '0;
      sw_lvl_ff  <= '0;
    end else begin
      btn_s1_ff <= button_press;
      btn_s2_ff <= btn_s1_ff;
      btn_s3_ff <= btn_s2_ff;
      if (btn_s2_ff == btn_s3_ff) begin
        btn_lvl_ff <= btn_s3_ff;
      end
      sw_s1_ff <= dip_switch_in;
      sw_s2_ff <= sw_s1_ff;
      sw_s3_ff <= sw_s2_ff;
      for (int i = 0; i < SW_W; i++) begin
        if (sw_s2_ff[i] == sw_s3_ff[i]) begin
          sw_lvl_ff[i] <= sw_s3_ff[i];
        end
      end
    end
  end

  // Rising edge of the accepted level; reset level matches the idle pin
  logic press_evt;
  assign press_evt = (btn_s2_ff == btn_s3_ff) && btn_s3_ff && !btn_lvl_ff;

  // Oscillator lock
  logic [15:0] key_ff;
  logic        locked_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_ff    <= '0;
      locked_ff <= 1'b1;
    end else if (wr_acc && hit(paddr, OFS_LOCK)) begin
      key_ff    <= pwdata[KEY_MSB:0];
      locked_ff <= (pwdata != {16'h0000, UNLOCK_KEY});
    end
  end

  // Oscillator divisor registers, writable only while unlocked
  logic [31:0] osc1_ff, osc2_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc1_ff <= OSC1_RST;
      osc2_ff <= OSC2_RST;
    end else if (wr_acc && !locked_ff) begin
      if (hit(paddr, OFS_OSC1)) begin
        osc1_ff <= pwdata;
      end
      if (hit(paddr, OFS_OSC2)) begin
        osc2_ff <= pwdata;
      end
    end
  end
  assign osc1_div = osc1_ff;
  assign osc2_div = osc2_ff;

  // User LEDs, all dark after reset
  logic [LED_W-1:0] led_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_ff <= '1;
    end else if (wr_acc && hit(paddr, OFS_LEDS)) begin
      led_ff <= pwdata[LED_W-1:0];
    end
  end
  assign user_led_outputs_n = led_ff;

  // Button latch; a press in the clearing cycle wins
  logic irq_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (press_evt) begin
      irq_ff <= 1'b1;
    end else if (wr_acc && hit(paddr, OFS_IRQ)) begin
      irq_ff <= pwdata[0];
    end
  end
  assign button_irq = irq_ff;

  // Display control
  logic       disp_en_ff;
  lmcr_disp_e disp_sel_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disp_en_ff  <= DISP_EN_RST;
      disp_sel_ff <= LMCR_DISP_PANEL;
    end else if (wr_acc && hit(paddr, OFS_CTRL)) begin
      disp_en_ff  <= pwdata[DISP_EN_BIT];
      disp_sel_ff <= lmcr_disp_e'(pwdata[DISP_SEL_MSB:0]);
    end
  end
  assign display_enable = disp_en_ff;
  assign display_select = disp_sel_ff;

  // Read mux, sampled in the setup phase so data is registered at access
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = WORD_ZERO;
    if (in_rom) begin
      nxt_rdata = rom[paddr[ROM_IDX_LSB+:ROM_IDX_W]];
    end else if (hit(paddr, OFS_OSC1)) begin
      nxt_rdata = osc1_ff;
    end else if (hit(paddr, OFS_OSC2)) begin
      nxt_rdata = osc2_ff;
    end else if (hit(paddr, OFS_LOCK)) begin
      nxt_rdata = {15'h0000, locked_ff, key_ff};
    end else if (hit(paddr, OFS_LEDS)) begin
      nxt_rdata[LED_W-1:0] = led_ff;
    end else if (hit(paddr, OFS_IRQ)) begin
      nxt_rdata[0] = irq_ff;
    end else if (hit(paddr, OFS_SWITCH)) begin
      nxt_rdata[SW_W-1:0] = sw_lvl_ff;
    end else if (hit(paddr, OFS_CTRL)) begin
      nxt_rdata[DISP_EN_BIT:0] = {disp_en_ff, disp_sel_ff};
    end
  end

  logic [31:0] rdata_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= WORD_ZERO;
    end else if (rd_setup) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign prdata = rdata_ff;

  // Checks
  unlock_key_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && hit(paddr, OFS_LOCK) && pwdata == {16'h0000, UNLOCK_KEY} |=> !locked_ff)
    else $error("key write did not unlock");
  relock_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && hit(paddr, OFS_LOCK) && pwdata != {16'h0000, UNLOCK_KEY} |=> locked_ff)
    else $error("non-key write did not lock");
  osc_guard_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && locked_ff && hit(paddr, OFS_OSC1) |=> $stable(osc1_div))
    else $error("locked divisor was written");
  lock_status_a: assert property (@(posedge clk) disable iff (rst)
    rd_setup && hit(paddr, OFS_LOCK) ##1 psel && penable |-> prdata[LOCKED_BIT] == $past(locked_ff))
    else $error("lock status read wrong");
  led_drive_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && hit(paddr, OFS_LEDS) |=> user_led_outputs_n == $past(pwdata[LED_W-1:0]))
    else $error("LED pins do not follow write");
  press_latch_a: assert property (@(posedge clk) disable iff (rst)
    press_evt |=> button_irq ##1 (button_irq || $past(wr_acc && hit(paddr, OFS_IRQ))))
    else $error("press not latched onto interrupt");
  irq_clear_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && hit(paddr, OFS_IRQ) && !pwdata[0] && !press_evt |=> !button_irq)
    else $error("write 0 did not clear latch");
  irq_set_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && hit(paddr, OFS_IRQ) && pwdata[0] |=> button_irq)
    else $error("write 1 did not set latch");
  ctrl_reserved_a: assert property (@(posedge clk) disable iff (rst)
    rd_setup && hit(paddr, OFS_CTRL) |=> prdata[7:3] == 5'h00)
    else $error("reserved control bits not zero");
  build_word_a: assert property (@(posedge clk) disable iff (rst)
    rd_setup && in_rom && paddr[ROM_IDX_LSB+:ROM_IDX_W] == 5'h1F |=> prdata[31:8] == BUILD_TAG)
    else $error("build word malformed");

  // Lock and divisor checks
  key_field_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && hit(paddr, OFS_LOCK) |=> key_ff == $past(pwdata[KEY_MSB:0]))
    else $error("key field not stored");
  lock_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_setup && hit(paddr, OFS_LOCK) |=> prdata[KEY_MSB:0] == $past(key_ff))
    else $error("key field read wrong");
  lock_reset_a: assert property (@(posedge clk)
    $fell(rst) |-> locked_ff && key_ff == '0)
    else $error("lock not locked after reset");
  osc_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && !locked_ff && hit(paddr, OFS_OSC1) |=> osc1_div == $past(pwdata))
    else $error("unlocked divisor write lost");
  osc2_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && !locked_ff && hit(paddr, OFS_OSC2) |=> osc2_div == $past(pwdata))
    else $error("unlocked divisor write lost");
  osc2_guard_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && locked_ff && hit(paddr, OFS_OSC2) |=> $stable(osc2_div))
    else $error("locked divisor was written");

  // Button and switch checks
  irq_hold_a: assert property (@(posedge clk) disable iff (rst)
    button_irq && !(wr_acc && hit(paddr, OFS_IRQ)) |=> button_irq)
    else $error("latch dropped without a clear");
  switch_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_setup && hit(paddr, OFS_SWITCH) |=> prdata[SW_W-1:0] == $past(sw_lvl_ff))
    else $error("switch state read wrong");

  // Display checks
  disp_enable_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && hit(paddr, OFS_CTRL) |=> display_enable == $past(pwdata[DISP_EN_BIT]))
    else $error("display enable not written");
  disp_select_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && hit(paddr, OFS_CTRL) |=> display_select == $past(pwdata[DISP_SEL_MSB:0]))
    else $error("display route not written");
  disp_reset_a: assert property (@(posedge clk)
    $fell(rst) |-> display_enable && display_select == LMCR_DISP_PANEL)
    else $error("display reset state wrong");

  // Information ROM checks
  rom_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_setup && in_rom && paddr[ROM_IDX_LSB+:ROM_IDX_W] == 5'h00 |=> prdata == ROM_INIT[0])
    else $error("first entry read wrong");
  rom_build_low_a: assert property (@(posedge clk) disable iff (rst)
    rd_setup && in_rom && paddr[ROM_IDX_LSB+:ROM_IDX_W] == 5'h1F |=> prdata[7:0] == {BUILD_MAJ, BUILD_MIN})
    else $error("build revision byte wrong");

endmodule

// File: test/lmcr_cpu_model.sv
// Processor-side bus master model issuing single register transfers
module lmcr_cpu_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [27:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 28'h000_0000;
    pwdata = 32'h0000_0000;
  end
  // Setup then access, held until ready is sampled high
  task automatic xfer(input logic wr, input logic [27:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(negedge clk);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    q = prdata;
    // A wait that runs out is reported as a bus error
    err = pslverr || (n >= 16);
    @(negedge clk);
    // Released address and data lines show inverted values, never stale ones
    psel = 1'b0;
    penable = 1'b0;
    paddr = ~paddr;
    pwdata = ~pwdata;
  endtask
endmodule

// File: test/logic_module_control_regs_tb_top.sv
// Self-checking bench for the logic-module control register bank
module logic_module_control_regs_tb_top import lmcr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ROM_W0 = 32'h4807_7712; // Arbitrary type code and revision
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, irq, disp_en, err;
  logic [27:0] paddr;
  logic [31:0] pwdata, prdata, q, osc1, osc2;
  logic        button_press = 1'b0;
  logic [7:0]  dip_switch_in = 8'hFF;
  logic [7:0]  leds_n;
  logic [1:0]  disp_sel;
  int          mismatches = 0;
  int          comparisons = 0;
  // Design and bus master
  lmcr_regs #(.BUILD_MAJ(4'h2), .BUILD_MIN(4'h3), .ROM_INIT('{0: ROM_W0, default: 32'h0000_0000})) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .button_press(button_press),
    .dip_switch_in(dip_switch_in), .user_led_outputs_n(leds_n), .button_irq(irq),
    .display_enable(disp_en), .display_select(disp_sel), .osc1_div(osc1), .osc2_div(osc2));
  lmcr_cpu_model u_cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Clock
  always #5 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [27:0] a, input logic [31:0] d);
    u_cpu.xfer(1'b1, a, d, q, err);
    chk(32'(err), 32'h0000_0000);
  endtask
  task automatic rd(input logic [27:0] a, input logic [31:0] exp);
    u_cpu.xfer(1'b0, a, 32'h0000_0000, q, err);
    chk(q, exp);
    chk(32'(err), 32'h0000_0000);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (comparisons > 0 && mismatches == 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #200_000;
    mismatches++;
    results;
  end
  // Test sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk(32'(pready), 32'h0000_0001);
    rd(OFS_LOCK, 32'h0001_0000);
    rd(OFS_CTRL, 32'h0000_0004);
    chk(32'(leds_n), 32'h0000_00FF);
    $display("test reset done");
    wr(OFS_OSC1, 32'h1234_5678);
    rd(OFS_OSC1, 32'h0000_0000);
    wr(OFS_LOCK, 32'h0000_A05F);
    rd(OFS_LOCK, 32'h0000_A05F);
    wr(OFS_OSC1, 32'h1234_5678);
    chk(osc1, 32'h1234_5678);
    wr(OFS_OSC2, 32'h0000_5A5A);
    chk(osc2, 32'h0000_5A5A);
    wr(OFS_LOCK, 32'h0001_A05F);
    rd(OFS_LOCK, 32'h0001_A05F);
    wr(OFS_OSC2, 32'h0BAD_F00D);
    chk(osc2, 32'h0000_5A5A);
    $display("test lock done");
    wr(OFS_LEDS, 32'h0000_00A5);
    chk(32'(leds_n), 32'h0000_00A5);
    button_press = 1'b1;
    repeat (6) @(negedge clk);
    button_press = 1'b0;
    repeat (6) @(negedge clk);
    chk(32'(irq), 32'h0000_0001);
    rd(OFS_IRQ, 32'h0000_0001);
    wr(OFS_IRQ, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_IRQ, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_IRQ, 32'h0000_0000);
    dip_switch_in = 8'h3C;
    repeat (6) @(negedge clk);
    rd(OFS_SWITCH, 32'h0000_003C);
    $display("test pins done");
    // Every route with the display on and off, reserved bits written high
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL, 32'h0000_00F8 | 32'(i));
      rd(OFS_CTRL, 32'(i));
      chk(32'(disp_sel), 32'(i[1:0]));
      chk(32'(disp_en), 32'(i[2]));
    end
    $display("test display done");
    rd(OFS_ROM_BASE, ROM_W0);
    rd(OFS_ROM_BASE + 28'h000_0004, 32'h0000_0000);
    rd(OFS_ROM_BASE + 28'h000_007C, 32'hFFFF_FF23);
    wr(OFS_ROM_BASE, 32'h0000_0000);
    rd(OFS_ROM_BASE, ROM_W0);
    u_cpu.xfer(1'b0, 28'h000_0100, 32'h0000_0000, q, err);
    chk(q, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    $display("test rom done");
    results;
  end
endmodule
